// ---- hw/amp_status_monitor_regs.sv ----
// status monitor register bank of the amplifier; monitor bits read-only, reserved bits writable
//
// Function
// - pll monitor bit 4 shows pll enabled (1) or disabled (0).
// - bits 2-0 encode pll source: master clk, bit clk, oscillator, gp pin; others mute.
// - source shows auto choice when auto setup active, else programmed one.
// - analog power bit 7 shows charge pump active.
// - analog power bit 6 shows analog reference active.
// - analog power bit 5 shows line driver active.
// - analog power bit 4 shows line bias active.
// - analog power bit 3 shows line common-mode feedback active.
// - analog power bit 2 shows left output stage active.
// - analog power bit 1 shows right output stage active.
// - analog power bit 0 shows dac active.
// - protection bit 7 shows offset compensator active.
// - protection bit 6 shows short protector active.
// - protection bit 5 shows impedance sensor active.
// - protection bit 4 shows whole impedance sensing circuitry active.
// - protection bit 3 is 0 while left short protector in reset.
// - protection bit 2 is 0 while right short protector in reset.
// - protection bit 1 is 0 while dac modulator in reset.
// - protection bit 0 is 0 while dac element matching in reset.
// - mute bits 5,4 show left/right dummy output unmuted.
// - mute bits 1,0 show left/right channel unmuted.
`timescale 1ns/10ps
module amp_status_monitor_regs
  import amp_monitor_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control port register access
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_hit_o,
  // live status sources
  input wire logic pll_on_flag_i,
  input wire logic auto_setup_i,
  input wire logic [2:0] auto_source_i,
  input wire logic [2:0] prog_source_i,
  input wire logic charge_pump_power_flag_i,
  input wire logic analog_ref_power_flag_i,
  input wire logic line_driver_power_flag_i,
  input wire logic line_bias_power_flag_i,
  input wire logic line_feedback_power_flag_i,
  input wire logic left_stage_power_flag_i,
  input wire logic right_stage_power_flag_i,
  input wire logic dac_power_flag_i,
  input wire logic offset_comp_power_flag_i,
  input wire logic short_guard_power_flag_i,
  input wire logic imp_sensor_power_flag_i,
  input wire logic imp_circuit_power_flag_i,
  input wire logic left_short_guard_run_flag_i,
  input wire logic right_short_guard_run_flag_i,
  input wire logic modulator_run_flag_i,
  input wire logic element_match_run_flag_i,
  input wire logic left_dummy_unmute_flag_i,
  input wire logic right_dummy_unmute_flag_i,
  input wire logic left_unmute_flag_i,
  input wire logic right_unmute_flag_i,
  // decoded source, for the clock tree
  output logic [2:0] pll_source_field_o,
  output logic pll_source_mute_o
);

  // ****************************************
  // source selection
  // ****************************************
  logic [2:0] source_sel;

  pll_source_select u_src (
    .auto_setup_i(auto_setup_i),
    .auto_source_i(auto_source_i),
    .prog_source_i(prog_source_i),
    .source_o(source_sel)
  );

  // ****************************************
  // status sampling
  // ****************************************
  logic [7:0] pll_mon_r;
  logic [7:0] power_mon_r;
  logic [7:0] protect_mon_r;
  logic [7:0] mute_mon_r;
  logic [7:0] pll_live;
  logic [7:0] power_live;
  logic [7:0] protect_live;
  logic [7:0] mute_live;
  // writable reserved bits kept so software reads back what it wrote
  logic [2:0] pll_rsvd_hi_r;
  logic pll_rsvd_lo_r;
  logic [1:0] mute_rsvd_hi_r;
  logic [1:0] mute_rsvd_lo_r;

  // live status assembled into register layouts
  assign pll_live = {pll_rsvd_hi_r,
                     pll_on_flag_i,
                     pll_rsvd_lo_r,
                     source_sel};
  assign power_live = {charge_pump_power_flag_i,
                       analog_ref_power_flag_i,
                       line_driver_power_flag_i,
                       line_bias_power_flag_i,
                       line_feedback_power_flag_i,
                       left_stage_power_flag_i,
                       right_stage_power_flag_i,
                       dac_power_flag_i};
  assign protect_live = {offset_comp_power_flag_i,
                         short_guard_power_flag_i,
                         imp_sensor_power_flag_i,
                         imp_circuit_power_flag_i,
                         left_short_guard_run_flag_i,
                         right_short_guard_run_flag_i,
                         modulator_run_flag_i,
                         element_match_run_flag_i};
  assign mute_live = {mute_rsvd_hi_r,
                      left_dummy_unmute_flag_i,
                      right_dummy_unmute_flag_i,
                      mute_rsvd_lo_r,
                      left_unmute_flag_i,
                      right_unmute_flag_i};

  // one sampling stage into the register clock domain
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_mon_r <= RSVD_RESET;
      power_mon_r <= RSVD_RESET;
      protect_mon_r <= RSVD_RESET;
      mute_mon_r <= RSVD_RESET;
    end else begin
      pll_mon_r <= pll_live;
      power_mon_r <= power_live;
      protect_mon_r <= protect_live;
      mute_mon_r <= mute_live;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  logic sel_pll;
  logic sel_power;
  logic sel_protect;
  logic sel_mute;

  // one offset compare shared by the write, hit and read decodes
  function automatic logic offset_is(input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs);
    offset_is = (addr == ofs);
  endfunction

  // one select per mapped register, so all decodes agree on the map
  assign sel_pll = offset_is(reg_addr_i, PLL_STATE_MONITOR_ADDR);
  assign sel_power = offset_is(reg_addr_i, ANALOG_POWER_MONITOR_ADDR);
  assign sel_protect = offset_is(reg_addr_i, PROTECT_RESET_MONITOR_ADDR);
  assign sel_mute = offset_is(reg_addr_i, MUTE_STATE_MONITOR_ADDR);

  // ****************************************
  // write decode
  // ****************************************
  logic wr_pll;
  logic wr_mute;

  // only reserved r/w bits accept data; monitor bits ignore writes
  assign wr_pll = reg_wr_i && sel_pll;
  assign wr_mute = reg_wr_i && sel_mute;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_rsvd_hi_r <= 3'h0;
      pll_rsvd_lo_r <= 1'b0;
      mute_rsvd_hi_r <= 2'h0;
      mute_rsvd_lo_r <= 2'h0;
    end else begin
      if (wr_pll) begin
        pll_rsvd_hi_r <= reg_wdata_i[PLL_RSVD_HI_LSB +: 3];
        pll_rsvd_lo_r <= reg_wdata_i[PLL_RSVD_LO_BIT];
      end
      if (wr_mute) begin
        mute_rsvd_hi_r <= reg_wdata_i[MUTE_RSVD_HI_LSB +: 2];
        mute_rsvd_lo_r <= reg_wdata_i[MUTE_RSVD_LO_LSB +: 2];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_mux;
  logic addr_hit;

  // unmapped offsets read zero and do not raise hit
  assign addr_hit = sel_pll || sel_power || sel_protect || sel_mute;
  assign rd_mux = sel_pll ? pll_mon_r :
                  sel_power ? power_mon_r :
                  sel_protect ? protect_mon_r :
                  sel_mute ? mute_mon_r : 8'h00;

  // read data registered, held until the next read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  assign reg_hit_o = (reg_rd_i || reg_wr_i) && addr_hit;

  // source field out, reserved codes flag mute
  assign pll_source_field_o = pll_mon_r[PLL_SOURCE_LSB +: PLL_SOURCE_W];
  assign pll_source_mute_o = (pll_source_field_o > SRC_GP_PIN);
endmodule

// ---- hw/amp_monitor_pkg.sv ----
// package: offsets, field positions and encodings of the status monitor bank
package amp_monitor_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets on the control port
  localparam logic [7:0] PLL_STATE_MONITOR_ADDR = 8'h69;
  localparam logic [7:0] ANALOG_POWER_MONITOR_ADDR = 8'h6a;
  localparam logic [7:0] PROTECT_RESET_MONITOR_ADDR = 8'h6b;
  localparam logic [7:0] MUTE_STATE_MONITOR_ADDR = 8'h6c;
  // pll_state_monitor fields
  localparam int PLL_ON_FLAG_BIT = 4;
  localparam int PLL_SOURCE_LSB = 0;
  localparam int PLL_SOURCE_W = 3;
  localparam int PLL_RSVD_HI_LSB = 5;
  localparam int PLL_RSVD_LO_BIT = 3;
  // pll source encodings, all others reserved and mean mute
  localparam logic [2:0] SRC_MASTER_CLK = 3'h0;
  localparam logic [2:0] SRC_BIT_CLK = 3'h1;
  localparam logic [2:0] SRC_INTERNAL_OSCILLATOR = 3'h2;
  localparam logic [2:0] SRC_GP_PIN = 3'h3;
  // mute_state_monitor fields
  localparam int LEFT_DUMMY_UNMUTE_BIT = 5;
  localparam int RIGHT_DUMMY_UNMUTE_BIT = 4;
  localparam int LEFT_UNMUTE_BIT = 1;
  localparam int RIGHT_UNMUTE_BIT = 0;
  localparam int MUTE_RSVD_HI_LSB = 6;
  localparam int MUTE_RSVD_LO_LSB = 2;
  // reset value of the sampled monitor registers
  localparam logic [7:0] RSVD_RESET = 8'h00;
endpackage

// ---- hw/pll_source_select.sv ----
// pll reference source selection between automatic and programmed choice
`timescale 1ns/10ps
module pll_source_select
  import amp_monitor_pkg::*;
(
  input wire logic auto_setup_i,
  input wire logic [2:0] auto_source_i,
  input wire logic [2:0] prog_source_i,
  output logic [2:0] source_o
);
  // auto setup overrides the programmed source while active
  assign source_o = auto_setup_i ? auto_source_i : prog_source_i;
endmodule

// ---- bench/amp_status_monitor_regs_props.sv ----
// concurrent checks on the ports of the status monitor register bank
`timescale 1ns/10ps
module amp_status_props
  import amp_monitor_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_rd_i, reg_wr_i, reg_hit_o, pll_source_mute_o, auto_setup_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [2:0] auto_source_i, prog_source_i, pll_source_field_o,
  input wire logic pll_on_flag_i, charge_pump_power_flag_i, analog_ref_power_flag_i,
  input wire logic line_driver_power_flag_i, line_bias_power_flag_i, line_feedback_power_flag_i,
  input wire logic left_stage_power_flag_i, right_stage_power_flag_i, dac_power_flag_i,
  input wire logic offset_comp_power_flag_i, short_guard_power_flag_i, imp_sensor_power_flag_i,
  input wire logic imp_circuit_power_flag_i, left_short_guard_run_flag_i,
  input wire logic right_short_guard_run_flag_i, modulator_run_flag_i, element_match_run_flag_i,
  input wire logic left_dummy_unmute_flag_i, right_dummy_unmute_flag_i,
  input wire logic left_unmute_flag_i, right_unmute_flag_i
);
  // ****************************************
  // packed status views and decoded reads
  // ****************************************
  wire [7:0] pwr = {charge_pump_power_flag_i, analog_ref_power_flag_i, line_driver_power_flag_i,
    line_bias_power_flag_i, line_feedback_power_flag_i, left_stage_power_flag_i,
    right_stage_power_flag_i, dac_power_flag_i};
  wire [7:0] prt = {offset_comp_power_flag_i, short_guard_power_flag_i, imp_sensor_power_flag_i,
    imp_circuit_power_flag_i, left_short_guard_run_flag_i, right_short_guard_run_flag_i,
    modulator_run_flag_i, element_match_run_flag_i};
  wire [3:0] mut = {left_dummy_unmute_flag_i, right_dummy_unmute_flag_i, left_unmute_flag_i,
    right_unmute_flag_i};
  wire [2:0] src = auto_setup_i ? auto_source_i : prog_source_i;
  wire rd_pll = reg_rd_i && reg_addr_i == PLL_STATE_MONITOR_ADDR;
  wire rd_pwr = reg_rd_i && reg_addr_i == ANALOG_POWER_MONITOR_ADDR;
  wire rd_prt = reg_rd_i && reg_addr_i == PROTECT_RESET_MONITOR_ADDR;
  wire rd_mut = reg_rd_i && reg_addr_i == MUTE_STATE_MONITOR_ADDR;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ****************************************
  // read data is live status two edges back: sample edge, then read edge
  // ****************************************
  AST_PLL_READ: assert property (rd_pll && $past(rst_b_i)
    |=> {reg_rdata_o[4], reg_rdata_o[2:0]} == $past({pll_on_flag_i, src}, 2)) else $error("pll read");
  AST_POWER_READ: assert property (rd_pwr && $past(rst_b_i)
    |=> reg_rdata_o == $past(pwr, 2)) else $error("power read");
  AST_PROTECT_READ: assert property (rd_prt && $past(rst_b_i)
    |=> reg_rdata_o == $past(prt, 2)) else $error("protect read");
  AST_MUTE_READ: assert property (rd_mut && $past(rst_b_i)
    |=> {reg_rdata_o[5:4], reg_rdata_o[1:0]} == $past(mut, 2)) else $error("mute read");
  AST_SRC_FIELD: assert property ($past(rst_b_i) |-> pll_source_field_o == $past(src))
    else $error("source field");
  AST_SRC_MUTE: assert property (pll_source_mute_o == (pll_source_field_o > 3'h3))
    else $error("source mute");
  AST_HIT: assert property (reg_hit_o == ((reg_rd_i || reg_wr_i)
    && reg_addr_i >= 8'h69 && reg_addr_i <= 8'h6c)) else $error("hit decode");
  AST_UNMAPPED: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  AST_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
endmodule

bind amp_status_monitor_regs amp_status_props u_props (.*);

// ---- bench/tb_amp_status_monitor_regs.sv ----
// self-checking bench for the status monitor register bank
`timescale 1ns/10ps
module tb_amp_status_monitor_regs;
  import amp_monitor_pkg::*;
  logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_hit_o, pll_source_mute_o, auto_setup_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, r69, r6c;
  logic [2:0] auto_source_i, prog_source_i, pll_source_field_o, src;
  logic [20:0] st;
  logic [31:0] r;
  int failures, n_compared, seed, i;
  assign src = auto_setup_i ? auto_source_i : prog_source_i;
  // status vector: pll on, power byte, protect byte, mute nibble
  amp_status_monitor_regs dut (.*, .pll_on_flag_i(st[20]), .charge_pump_power_flag_i(st[19]),
    .analog_ref_power_flag_i(st[18]), .line_driver_power_flag_i(st[17]),
    .line_bias_power_flag_i(st[16]), .line_feedback_power_flag_i(st[15]),
    .left_stage_power_flag_i(st[14]), .right_stage_power_flag_i(st[13]),
    .dac_power_flag_i(st[12]), .offset_comp_power_flag_i(st[11]),
    .short_guard_power_flag_i(st[10]), .imp_sensor_power_flag_i(st[9]),
    .imp_circuit_power_flag_i(st[8]), .left_short_guard_run_flag_i(st[7]),
    .right_short_guard_run_flag_i(st[6]), .modulator_run_flag_i(st[5]),
    .element_match_run_flag_i(st[4]), .left_dummy_unmute_flag_i(st[3]),
    .right_dummy_unmute_flag_i(st[2]), .left_unmute_flag_i(st[1]), .right_unmute_flag_i(st[0]));
  // ****************************************
  // expected values and compares
  // ****************************************
  function automatic logic [7:0] expv(input logic [7:0] a);
    case (a)
      PLL_STATE_MONITOR_ADDR: expv = (r69 & 8'he8) | {3'h0, st[20], 1'b0, src};
      ANALOG_POWER_MONITOR_ADDR: expv = st[19:12];
      PROTECT_RESET_MONITOR_ADDR: expv = st[11:4];
      MUTE_STATE_MONITOR_ADDR: expv = (r6c & 8'hcc) | {2'h0, st[3:2], 2'h0, st[1:0]};
      default: expv = 8'h00;
    endcase
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  // read strobe is left high so back-to-back reads never double-drive it
  task automatic rd(input logic [7:0] ra);
    reg_addr_i = ra;
    reg_rd_i = 1'b1;
    #1 chk1(reg_hit_o, ra >= 8'h69 && ra <= 8'h6c);
    @(negedge clk_i);
    chk8(reg_rdata_o, expv(ra));
  endtask
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    reg_rd_i = 1'b0;
    reg_addr_i = wa;
    reg_wdata_i = wd;
    reg_wr_i = 1'b1;
    #1 chk1(reg_hit_o, wa >= 8'h69 && wa <= 8'h6c);
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    if (wa == PLL_STATE_MONITOR_ADDR) r69 = wd;
    if (wa == MUTE_STATE_MONITOR_ADDR) r6c = wd;
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // clock, stimulus and watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // walking one over status, every source code, then random traffic
  initial begin
    seed = 32'h76686bf0;
    {failures, n_compared, rst_b_i, reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
    {st, auto_setup_i, auto_source_i, prog_source_i, r69, r6c} = '0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      reg_rd_i = 1'b0;
      // mid-run reset: outputs and stored reserved bits must clear
      if (i == 150) begin
        rst_b_i = 1'b0;
        @(negedge clk_i);
        chk8(reg_rdata_o, 8'h00);
        chk8({5'h0, pll_source_field_o}, 8'h00);
        chk1(pll_source_mute_o, 1'b0);
        rst_b_i = 1'b1;
        {r69, r6c} = '0;
      end
      st = (i < 21) ? 21'h1 << i : r[20:0];
      r = $random(seed);
      {auto_setup_i, auto_source_i, prog_source_i} = (i < 16) ? {i[3], i[2:0], ~i[2:0]} : r[6:0];
      @(negedge clk_i);
      chk1(pll_source_mute_o, src > 3'h3);
      chk8({5'h0, pll_source_field_o}, {5'h0, src});
      for (int k = 0; k < 4; k++) rd(8'h69 + k[7:0]);
      rd(8'h67 + {5'h0, r[9:7]});
      if (r[12]) wr(8'h67 + {5'h0, r[15:13]}, r[23:16]);
    end
    conclude;
  end
  initial begin
    #250000;
    failures++;
    conclude;
  end
endmodule
